//--- tc0_pkg.sv
package tc0_pkg;

    // register map, byte offsets on the register port
    localparam int          ADDR_W       = 3;
    localparam logic [2:0]  OFS_CTRL_A   = 3'h0;
    localparam logic [2:0]  OFS_CTRL_B   = 3'h1;
    localparam logic [2:0]  OFS_COUNT    = 3'h2;
    localparam logic [2:0]  OFS_CMP_A    = 3'h3;
    localparam logic [2:0]  OFS_CMP_B    = 3'h4;
    localparam logic [2:0]  OFS_FLAG     = 3'h5;
    localparam logic [2:0]  OFS_MASK     = 3'h6;

    // field positions
    localparam int CTA_COM_A_LSB = 6;
    localparam int CTA_COM_B_LSB = 4;
    localparam int CTA_WGM_LSB   = 0;
    localparam int CTB_FORCE_A   = 7;
    localparam int CTB_FORCE_B   = 6;
    localparam int CTB_WGM_HI    = 3;
    localparam int CTB_CS_LSB    = 0;
    localparam int FLG_OVF       = 0;
    localparam int FLG_MATCH_A   = 1;
    localparam int FLG_MATCH_B   = 2;
    localparam int NUM_FLAGS     = 3;

    // values
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [7:0] BOTTOM_VAL = 8'h00;
    localparam logic [7:0] MAX_VAL    = 8'hFF;
    localparam logic [7:0] STEP_VAL   = 8'h01;
    localparam logic [2:0] RST_FLAGS  = 3'h0;
    localparam logic [1:0] RST_COM    = 2'h0;

    typedef enum logic [2:0] {
        WGM_NORMAL    = 3'h0,
        WGM_PC_MAX    = 3'h1,
        WGM_CTC       = 3'h2,
        WGM_FAST_MAX  = 3'h3,
        WGM_RSV4      = 3'h4,
        WGM_PC_OCRA   = 3'h5,
        WGM_RSV6      = 3'h6,
        WGM_FAST_OCRA = 3'h7
    } tc0_wgm_t;

    typedef enum logic [2:0] {
        CS_STOP     = 3'h0,
        CS_DIV1     = 3'h1,
        CS_DIV8     = 3'h2,
        CS_DIV64    = 3'h3,
        CS_DIV256   = 3'h4,
        CS_DIV1024  = 3'h5,
        CS_EXT_FALL = 3'h6,
        CS_EXT_RISE = 3'h7
    } tc0_cs_t;

    typedef enum logic [1:0] {
        CLS_NONPWM = 2'h0,
        CLS_FAST   = 2'h1,
        CLS_PHASE  = 2'h2
    } tc0_cls_t;

    typedef enum logic {
        DIR_UP   = 1'b0,
        DIR_DOWN = 1'b1
    } tc0_dir_t;

    // per-channel events handed to the waveform logic
    typedef struct packed {
        logic tick;
        logic match;
        logic at_top;
        logic down;
        logic force_cmp;
    } tc0_chev_t;

    function automatic tc0_cls_t wgm_class(input tc0_wgm_t wgm);
        tc0_cls_t cls;
        cls = CLS_NONPWM;
        if (wgm == WGM_FAST_MAX || wgm == WGM_FAST_OCRA) begin
            cls = CLS_FAST;
        end else if (wgm == WGM_PC_MAX || wgm == WGM_PC_OCRA) begin
            cls = CLS_PHASE;
        end
        return cls;
    endfunction

    function automatic logic top_from_cmp_a(input tc0_wgm_t wgm);
        return (wgm == WGM_CTC) || (wgm == WGM_PC_OCRA) || (wgm == WGM_FAST_OCRA);
    endfunction

endpackage

//--- tc0_clk_sel.sv
`timescale 1ns/1ps
module tc0_clk_sel (
    input  wire logic              mclk_i,        // system clock
    input  wire logic              arst_n_i,      // async reset, active low
    input  wire logic              ce_i,          // clock enable
    input  wire tc0_pkg::tc0_cs_t  cs_i,          // clock select field
    input  wire logic [3:0]        presc_tick_i,  // prescaler ticks /8 /64 /256 /1024
    input  wire logic              ext_pin_i,     // raw external count pin
    output logic                   tick_o         // one-cycle timer tick
);
    import tc0_pkg::*;

    logic ext_s1;
    logic ext_s2;
    logic ext_prev;

    // pin is asynchronous: two stages, then edge detect on the second
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ext_s1   <= 1'b0;
            ext_s2   <= 1'b0;
            ext_prev <= 1'b0;
        end else if (ce_i) begin
            ext_s1   <= ext_pin_i;
            ext_s2   <= ext_s1;
            ext_prev <= ext_s2;
        end
    end

    always_comb begin
        unique case (cs_i)
            CS_STOP:     tick_o = 1'b0;
            CS_DIV1:     tick_o = ce_i;
            CS_DIV8:     tick_o = ce_i & presc_tick_i[0];
            CS_DIV64:    tick_o = ce_i & presc_tick_i[1];
            CS_DIV256:   tick_o = ce_i & presc_tick_i[2];
            CS_DIV1024:  tick_o = ce_i & presc_tick_i[3];
            CS_EXT_FALL: tick_o = ce_i & ext_prev & ~ext_s2;
            CS_EXT_RISE: tick_o = ce_i & ~ext_prev & ext_s2;
        endcase
    end

endmodule // tc0_clk_sel

//--- tc0_wave_ch.sv
`timescale 1ns/1ps
module tc0_wave_ch (
    input  wire logic                mclk_i,     // system clock
    input  wire logic                arst_n_i,   // async reset, active low
    input  wire logic                ce_i,       // clock enable
    input  wire logic [1:0]          com_i,      // compare output mode
    input  wire tc0_pkg::tc0_cls_t   cls_i,      // waveform class
    input  wire logic                toggle_ok_i,// toggle allowed in pwm modes
    input  wire tc0_pkg::tc0_chev_t  ev_i,       // channel events
    output logic                     wave_o,     // compare output state
    output logic                     wave_en_o   // output overrides pin
);
    import tc0_pkg::*;

    logic next_wave;
    logic hit;

    assign hit = ev_i.tick & ev_i.match;

    always_comb begin
        next_wave = wave_o;
        unique case (cls_i)
            CLS_NONPWM: begin
                if (hit || ev_i.force_cmp) begin
                    unique case (com_i)
                        2'h0: next_wave = wave_o;
                        2'h1: next_wave = ~wave_o;
                        2'h2: next_wave = 1'b0;
                        2'h3: next_wave = 1'b1;
                    endcase
                end
            end
            CLS_FAST: begin
                if (com_i == 2'h1 && toggle_ok_i) begin
                    if (hit) next_wave = ~wave_o;
                end else if (com_i[1]) begin
                    // bottom wins so a compare at top gives a steady level
                    if (ev_i.tick && ev_i.at_top) begin
                        next_wave = ~com_i[0];
                    end else if (hit) begin
                        next_wave = com_i[0];
                    end
                end
            end
            CLS_PHASE: begin
                if (com_i == 2'h1 && toggle_ok_i) begin
                    if (hit) next_wave = ~wave_o;
                end else if (com_i[1] && hit) begin
                    next_wave = ev_i.down ? ~com_i[0] : com_i[0];
                end
            end
            default: next_wave = wave_o;
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wave_o    <= 1'b0;
            wave_en_o <= 1'b0;
        end else if (ce_i) begin
            wave_o    <= next_wave;
            wave_en_o <= (com_i != RST_COM);
        end
    end

endmodule // tc0_wave_ch

//--- tc0_timer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - counter and both compare registers are 8-bit, processor readable and writable.
// - each interrupt source shows in the flag register, masked per bit.
// - timer clock from prescaled internal clock or external pin, edge selectable.
// - clock select zero gives no timer clock; counter stays stopped.
// - both compares checked continuously; equality sets flag and feeds waveform logic.
// - waveform logic makes pwm or frequency output on both compare pins.
// - bottom indication at count 0x00, maximum indication at count 0xFF.
// - top is 0xFF or compare register A, per mode; top indication given.
// - each timer clock clears, increments or decrements the counter per mode.
// - processor can read and write the counter at any time.
// - processor counter write beats clear or count in the same cycle.
// - three-bit waveform mode; two low bits in control A, high in B.
// - overflow flag set at a mode-dependent point; may request an interrupt.
// - zero-detect output asserts while the counter is zero.
// - match sets flag on next timer clock; cleared by service or writing one.
// - counter write blocks compare matches for the next timer clock.
// - mode zero counts up, wraps 0xFF to 0x00, overflow flags at zero.
// - compares double buffered in pwm modes; direct in normal and ctc.
module tc0_timer (
    input  wire logic                       mclk_i,          // system clock, 50 MHz
    input  wire logic                       arst_n_i,        // async reset, active low
    input  wire logic                       ce_i,            // clock enable, freezes state
    input  wire logic [tc0_pkg::ADDR_W-1:0] addr_i,          // register address
    input  wire logic [7:0]                 wdata_i,         // write data
    input  wire logic                       wr_i,            // write strobe
    input  wire logic                       rd_i,            // read strobe
    output logic      [7:0]                 rdata_o,         // read data, cycle after rd
    input  wire logic [3:0]                 presc_tick_i,    // prescaler taps
    input  wire logic                       ext_count_pin_i, // external count pin
    input  wire logic [2:0]                 irq_ack_i,       // interrupt serviced, per flag
    output logic      [2:0]                 irq_o,           // masked requests
    output logic                            wave_out_a_o,    // compare output a
    output logic                            wave_out_b_o,    // compare output b
    output logic                            wave_en_a_o,     // output a overrides pin
    output logic                            wave_en_b_o,     // output b overrides pin
    output logic                            zero_o,          // count is bottom
    output logic                            max_o,           // count is 0xFF
    output logic                            top_o            // count is top
);
    import tc0_pkg::*;

    // software-visible state
    logic      [7:0] count_value;
    logic      [7:0] compare_a_value;
    logic      [7:0] compare_b_value;
    logic      [7:0] cmp_a_buf;
    logic      [7:0] cmp_b_buf;
    logic      [1:0] com_a;
    logic      [1:0] com_b;
    tc0_wgm_t        waveform_mode_field;
    tc0_cs_t         clock_select_field;
    logic      [2:0] timer_flag_reg;
    logic      [2:0] timer_mask_reg;

    // internal state
    tc0_dir_t        dir;
    logic            blk;
    logic            force_a;
    logic            force_b;

    // combinational
    logic            timer_tick;
    tc0_cls_t        cls;
    logic      [7:0] top_val;
    logic            at_top;
    logic            at_bottom;
    logic            at_max;
    logic            match_a;
    logic            match_b;
    logic      [7:0] next_count;
    tc0_dir_t        next_dir;
    logic      [2:0] next_flag;
    logic      [2:0] flag_set;
    logic      [2:0] flag_clr;
    logic            ovf_hit;
    logic            buf_load;
    logic      [7:0] next_rdata;
    tc0_chev_t       ev_a;
    tc0_chev_t       ev_b;

    logic            wr_ctrl_a;
    logic            wr_ctrl_b;
    logic            wr_count;
    logic            wr_cmp_a;
    logic            wr_cmp_b;
    logic            wr_flag;
    logic            wr_mask;

    assign wr_ctrl_a = wr_i && (addr_i == OFS_CTRL_A);
    assign wr_ctrl_b = wr_i && (addr_i == OFS_CTRL_B);
    assign wr_count  = wr_i && (addr_i == OFS_COUNT);
    assign wr_cmp_a  = wr_i && (addr_i == OFS_CMP_A);
    assign wr_cmp_b  = wr_i && (addr_i == OFS_CMP_B);
    assign wr_flag   = wr_i && (addr_i == OFS_FLAG);
    assign wr_mask   = wr_i && (addr_i == OFS_MASK);

    tc0_clk_sel u_clk_sel (
        .mclk_i       (mclk_i),
        .arst_n_i     (arst_n_i),
        .ce_i         (ce_i),
        .cs_i         (clock_select_field),
        .presc_tick_i (presc_tick_i),
        .ext_pin_i    (ext_count_pin_i),
        .tick_o       (timer_tick)
    );

    // mode decode
    assign cls     = wgm_class(waveform_mode_field);
    assign top_val = top_from_cmp_a(waveform_mode_field) ? compare_a_value : MAX_VAL;
    assign at_top    = (count_value == top_val);
    assign at_bottom = (count_value == BOTTOM_VAL);
    assign at_max    = (count_value == MAX_VAL);

    // comparator; a counter write masks the next timer clock's match
    assign match_a = (count_value == compare_a_value) && !blk;
    assign match_b = (count_value == compare_b_value) && !blk;

    // counting sequence
    always_comb begin
        next_count = count_value;
        next_dir   = dir;
        if (wr_count) begin
            next_count = wdata_i;
        end else if (timer_tick) begin
            unique case (cls)
                CLS_NONPWM, CLS_FAST: begin
                    next_dir = DIR_UP;
                    // normal mode: top is 0xFF so this is the plain wrap
                    if (at_top) begin
                        next_count = BOTTOM_VAL;
                    end else begin
                        next_count = count_value + STEP_VAL;
                    end
                end
                CLS_PHASE: begin
                    if (dir == DIR_UP) begin
                        if (at_top) begin
                            next_dir   = DIR_DOWN;
                            next_count = count_value - STEP_VAL;
                        end else begin
                            next_count = count_value + STEP_VAL;
                        end
                    end else begin
                        if (at_bottom) begin
                            next_dir   = DIR_UP;
                            next_count = count_value + STEP_VAL;
                        end else begin
                            next_count = count_value - STEP_VAL;
                        end
                    end
                end
                default: next_count = count_value;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_value <= RST_BYTE;
            dir         <= DIR_UP;
        end else if (ce_i) begin
            count_value <= next_count;
            dir         <= next_dir;
        end
    end

    // match block, held until the next timer clock even while stopped
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            blk <= 1'b0;
        end else if (ce_i) begin
            if (wr_count) begin
                blk <= 1'b1;
            end else if (timer_tick) begin
                blk <= 1'b0;
            end
        end
    end

    // control fields
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            com_a               <= RST_COM;
            com_b               <= RST_COM;
            waveform_mode_field <= WGM_NORMAL;
            clock_select_field  <= CS_STOP;
        end else if (ce_i) begin
            if (wr_ctrl_a) begin
                com_a <= wdata_i[CTA_COM_A_LSB +: 2];
                com_b <= wdata_i[CTA_COM_B_LSB +: 2];
                waveform_mode_field <= tc0_wgm_t'({waveform_mode_field[2],
                                                   wdata_i[CTA_WGM_LSB +: 2]});
            end
            if (wr_ctrl_b) begin
                waveform_mode_field <= tc0_wgm_t'({wdata_i[CTB_WGM_HI],
                                                   waveform_mode_field[1:0]});
                clock_select_field  <= tc0_cs_t'(wdata_i[CTB_CS_LSB +: 3]);
            end
        end
    end

    // force strobes act only outside pwm modes and read back as zero
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            force_a <= 1'b0;
            force_b <= 1'b0;
        end else if (ce_i) begin
            force_a <= wr_ctrl_b && wdata_i[CTB_FORCE_A] && (cls == CLS_NONPWM);
            force_b <= wr_ctrl_b && wdata_i[CTB_FORCE_B] && (cls == CLS_NONPWM);
        end
    end

    // compare registers: buffer loads at top in pwm modes
    assign buf_load = timer_tick && at_top && (cls != CLS_NONPWM);

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmp_a_buf       <= RST_BYTE;
            cmp_b_buf       <= RST_BYTE;
            compare_a_value <= RST_BYTE;
            compare_b_value <= RST_BYTE;
        end else if (ce_i) begin
            if (wr_cmp_a) cmp_a_buf <= wdata_i;
            if (wr_cmp_b) cmp_b_buf <= wdata_i;
            if (cls == CLS_NONPWM) begin
                compare_a_value <= wr_cmp_a ? wdata_i : cmp_a_buf;
                compare_b_value <= wr_cmp_b ? wdata_i : cmp_b_buf;
            end else if (buf_load) begin
                compare_a_value <= cmp_a_buf;
                compare_b_value <= cmp_b_buf;
            end
        end
    end

    // overflow point per class
    always_comb begin
        unique case (cls)
            CLS_NONPWM: ovf_hit = at_max;
            CLS_FAST:   ovf_hit = at_top;
            CLS_PHASE:  ovf_hit = at_bottom;
            default:    ovf_hit = 1'b0;
        endcase
    end

    // flags: set wins over any clear arriving in the same cycle
    always_comb begin
        flag_set              = RST_FLAGS;
        flag_set[FLG_OVF]     = timer_tick && ovf_hit;
        flag_set[FLG_MATCH_A] = timer_tick && match_a;
        flag_set[FLG_MATCH_B] = timer_tick && match_b;
        flag_clr              = irq_ack_i | (wr_flag ? wdata_i[2:0] : RST_FLAGS);
        next_flag             = (timer_flag_reg & ~flag_clr) | flag_set;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            timer_flag_reg <= RST_FLAGS;
            timer_mask_reg <= RST_FLAGS;
            irq_o          <= RST_FLAGS;
        end else if (ce_i) begin
            timer_flag_reg <= next_flag;
            if (wr_mask) timer_mask_reg <= wdata_i[2:0];
            irq_o <= next_flag & (wr_mask ? wdata_i[2:0] : timer_mask_reg);
        end
    end

    // waveform channels
    always_comb begin
        ev_a.tick      = timer_tick;
        ev_a.match     = match_a;
        ev_a.at_top    = at_top;
        ev_a.down      = (dir == DIR_DOWN);
        ev_a.force_cmp = force_a;
        ev_b.tick      = timer_tick;
        ev_b.match     = match_b;
        ev_b.at_top    = at_top;
        ev_b.down      = (dir == DIR_DOWN);
        ev_b.force_cmp = force_b;
    end

    tc0_wave_ch u_wave_a (
        .mclk_i      (mclk_i),
        .arst_n_i    (arst_n_i),
        .ce_i        (ce_i),
        .com_i       (com_a),
        .cls_i       (cls),
        .toggle_ok_i (top_from_cmp_a(waveform_mode_field)),
        .ev_i        (ev_a),
        .wave_o      (wave_out_a_o),
        .wave_en_o   (wave_en_a_o)
    );

    tc0_wave_ch u_wave_b (
        .mclk_i      (mclk_i),
        .arst_n_i    (arst_n_i),
        .ce_i        (ce_i),
        .com_i       (com_b),
        .cls_i       (cls),
        .toggle_ok_i (1'b0),
        .ev_i        (ev_b),
        .wave_o      (wave_out_b_o),
        .wave_en_o   (wave_en_b_o)
    );

    // status outputs track the count that is being loaded
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            zero_o <= 1'b1;
            max_o  <= 1'b0;
            top_o  <= 1'b0;
        end else if (ce_i) begin
            zero_o <= (next_count == BOTTOM_VAL);
            max_o  <= (next_count == MAX_VAL);
            top_o  <= (next_count == top_val);
        end
    end

    // read path: compare reads return the buffer the processor writes
    always_comb begin
        next_rdata = RST_BYTE;
        if (rd_i) begin
            unique case (addr_i)
                OFS_CTRL_A: begin
                    next_rdata[CTA_COM_A_LSB +: 2] = com_a;
                    next_rdata[CTA_COM_B_LSB +: 2] = com_b;
                    next_rdata[CTA_WGM_LSB +: 2]   = waveform_mode_field[1:0];
                end
                OFS_CTRL_B: begin
                    next_rdata[CTB_WGM_HI]       = waveform_mode_field[2];
                    next_rdata[CTB_CS_LSB +: 3]  = clock_select_field;
                end
                OFS_COUNT: next_rdata = count_value;
                OFS_CMP_A: next_rdata = cmp_a_buf;
                OFS_CMP_B: next_rdata = cmp_b_buf;
                OFS_FLAG:  next_rdata[2:0] = timer_flag_reg;
                OFS_MASK:  next_rdata[2:0] = timer_mask_reg;
                default:   next_rdata = RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= RST_BYTE;
        end else if (ce_i) begin
            rdata_o <= next_rdata;
        end
    end

endmodule // tc0_timer

//--- tc0_timer_props.sv
`timescale 1ns/1ps
module tc0_timer_props
    import tc0_pkg::*;
(
    input wire logic              mclk_i,      // clock
    input wire logic              arst_n_i,    // reset
    input wire logic [ADDR_W-1:0] addr_i,      // address
    input wire logic [7:0]        wdata_i,     // write data
    input wire logic              wr_i,        // write strobe
    input wire logic              rd_i,        // read strobe
    input wire logic [7:0]        rdata_o,     // read data
    input wire logic [2:0]        irq_o,       // requests
    input wire logic              wave_en_a_o, // override a
    input wire logic              wave_en_b_o, // override b
    input wire logic              zero_o,      // bottom
    input wire logic              max_o        // max
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);
    wire wc = wr_i && addr_i == OFS_COUNT;
    wire wa = wr_i && addr_i == OFS_CTRL_A;

    a_rd_idle: assert property (!rd_i |=> rdata_o == 8'h00) else $error("rdata not idle");
    a_rd_unmap: assert property (rd_i && addr_i == 3'h7 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_cnt_zero: assert property (wc && wdata_i == BOTTOM_VAL |=> zero_o && !max_o)
        else $error("count write lost");
    a_cnt_max: assert property (wc && wdata_i == MAX_VAL |=> max_o && !zero_o)
        else $error("max flag wrong");
    a_cnt_nz: assert property (wc && wdata_i != BOTTOM_VAL |=> !zero_o)
        else $error("zero flag wrong");
    a_mask_off: assert property (wr_i && addr_i == OFS_MASK && wdata_i == 8'h00 |-> ##2 irq_o == 3'h0)
        else $error("masked request seen");
    a_en_a_on: assert property (wa && wdata_i[7:6] != 2'h0 |-> ##2 wave_en_a_o)
        else $error("output a not enabled");
    a_en_b_off: assert property (wa && wdata_i[5:4] == 2'h0 |-> ##2 !wave_en_b_o)
        else $error("output b enabled");
    c_ovf: cover property ($rose(irq_o[0]));
    c_match: cover property ($rose(irq_o[1]));
    c_wr: cover property (wc);
endmodule // tc0_timer_props

bind tc0_timer tc0_timer_props u_props (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .wave_en_a_o(wave_en_a_o), .wave_en_b_o(wave_en_b_o), .zero_o(zero_o), .max_o(max_o));

//--- tb.sv
`timescale 1ns/1ps
module tb;
    import tc0_pkg::*;
    logic       mclk_i = 1'b0;
    logic       arst_n_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic [3:0] presc_tick_i = 4'h0;
    logic       ext_count_pin_i = 1'b0;
    logic [2:0] irq_ack_i = 3'h0;
    logic [7:0] rdata_o;
    logic [2:0] irq_o;
    logic       zero_o;
    logic       top_o;
    logic       wave_out_a_o;
    logic [7:0] rv;
    int         bad_count = 0;
    int         check_count = 0;
    int         cyc = 0;

    tc0_timer dut_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .presc_tick_i(presc_tick_i), .ext_count_pin_i(ext_count_pin_i), .irq_ack_i(irq_ack_i),
        .irq_o(irq_o), .wave_out_a_o(wave_out_a_o), .wave_out_b_o(), .wave_en_a_o(),
        .wave_en_b_o(), .zero_o(zero_o), .max_o(), .top_o(top_o));

    initial forever #10 mclk_i = ~mclk_i;

    task automatic finish_test;
        $display("checks %0d bad %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // whole run needs a few hundred cycles
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 rv = rdata_o;
    endtask
    // bounded wait, so a dead flag ends as a mismatch, not a hang
    task automatic wirq(input int b);
        for (int i = 0; i < 40 && irq_o[b] !== 1'b1; i++) begin
            @(posedge mclk_i);
            #1;
        end
    endtask

    task automatic t_regs;
        #1 chk("zero", {7'h00, zero_o}, 8'h01);
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0]);
            chk("rst", rv, RST_BYTE);
        end
        for (int a = 2; a < 5; a++) begin
            wr(a[2:0], 8'hA5 ^ a[7:0]);
            rd(a[2:0]);
            chk("rw", rv, 8'hA5 ^ a[7:0]);
        end
        wr(OFS_COUNT, 8'h10);
        wt(20);
        rd(OFS_COUNT);
        chk("stop", rv, 8'h10);
        $display("t_regs done");
    endtask

    task automatic t_ovf;
        wr(OFS_MASK, 8'h01);
        wr(OFS_COUNT, 8'hFD);
        wr(OFS_CTRL_B, 8'h01);
        wirq(0);
        chk("wrap", {6'h00, irq_o[0], zero_o}, 8'h03);
        wr(OFS_CTRL_B, 8'h00);
        wr(OFS_FLAG, 8'h01);
        rd(OFS_FLAG);
        chk("clr", rv, 8'h00);
        $display("t_ovf done");
    endtask

    task automatic t_match;
        wr(OFS_CMP_A, 8'h05);
        wr(OFS_COUNT, 8'h05);
        wr(OFS_MASK, 8'h02);
        wr(OFS_CTRL_B, 8'h01);
        wt(8);
        chk("block", {5'h00, irq_o}, 8'h00);
        wr(OFS_COUNT, 8'h00);
        #1 chk("wins", {7'h00, zero_o}, 8'h01);
        wirq(1);
        chk("match", {5'h00, irq_o}, 8'h02);
        wr(OFS_CTRL_B, 8'h00);
        irq_ack_i <= 3'h2;
        @(posedge mclk_i);
        irq_ack_i <= 3'h0;
        rd(OFS_FLAG);
        chk("ack", rv, 8'h00);
        wr(OFS_MASK, 8'h00);
        $display("t_match done");
    endtask

    task automatic t_clk;
        for (int k = 0; k < 6; k++) begin
            wr(OFS_COUNT, 8'h00);
            wr(OFS_CTRL_B, 8'h02 + k[7:0]);
            for (int j = 0; j < 4; j++) begin
                ext_count_pin_i <= k > 3;
                presc_tick_i <= k < 4 ? 4'h1 << j : 4'h0;
                wt(1);
                presc_tick_i <= 4'h0;
                wt(4);
                ext_count_pin_i <= 1'b0;
                wt(4);
            end
            wr(OFS_CTRL_B, 8'h00);
            rd(OFS_COUNT);
            chk("clk", rv, k < 4 ? 8'h01 : 8'h04);
        end
        wr(OFS_CTRL_A, 8'h42);
        wr(OFS_COUNT, 8'h00);
        wr(OFS_CMP_A, 8'h03);
        wr(OFS_CTRL_B, 8'h01);
        wt(20);
        wr(OFS_CTRL_B, 8'h00);
        rd(OFS_COUNT);
        chk("ctc", {2'h0, rv[7:2]}, 8'h00);
        wr(OFS_COUNT, 8'h03);
        #1 chk("top", {7'h00, top_o}, 8'h01);
        rv = {7'h00, wave_out_a_o};
        wr(OFS_CTRL_B, 8'h80);
        wt(1);
        #1 chk("force", {7'h00, wave_out_a_o}, rv ^ 8'h01);
        $display("t_clk done");
    endtask

    initial begin
        wt(2);
        arst_n_i <= 1'b1;
        wt(1);
        t_regs();
        t_ovf();
        t_match();
        t_clk();
        finish_test();
    end
endmodule // tb
